// ---- rtl/clk_fanout_pkg.sv ----
// constants shared by the clock fanout buffer modules
package clk_fanout_pkg;
   // number of fanned-out clock outputs
   localparam int unsigned OUT_COUNT = 12;
   // clock source select encodings
   localparam logic SRC_DIFF = 1'b0;
   localparam logic SRC_REF = 1'b1;
   // reset values
   localparam logic RST_GATE_EN = 1'b0;
   localparam logic RST_LEVEL = 1'b0;
   localparam logic RST_OUT_LEVEL = 1'b0;
   // core clock period in ns, for reference of the oversampling rate
   localparam int unsigned CORE_CLK_PERIOD_NS = 25;
endpackage : clk_fanout_pkg

// ---- rtl/clk_src_if.sv ----
// selected clock level and its edge events between selector and gate
`timescale 1ns/1ps
`default_nettype none
interface clk_src_if;
   logic level;
   logic prev_level;
   logic fall;
   logic rise;
   modport source
   (
      output level,
      output prev_level,
      output fall,
      output rise
   );
   modport sink
   (
      input level,
      input prev_level,
      input fall,
      input rise
   );
endinterface : clk_src_if
`default_nettype wire

// ---- rtl/clk_source_select.sv ----
// picks the differential or reference clock and finds its edges
`timescale 1ns/1ps
`default_nettype none
module clk_source_select
   import clk_fanout_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // clock inputs
   input wire logic diff_clk_in_p,
   input wire logic diff_clk_in_n,
   input wire logic ref_test_clk_in,
   input wire logic clk_source_sel,
   // selected clock toward the gate
   clk_src_if.source src
);
   // a pair that is not complementary reads as low
   function automatic logic diff_decode(input logic p, input logic n);
      diff_decode = p & ~n;
   endfunction : diff_decode

   logic level;
   logic prev_level;
   wire logic diff_level;
   wire logic next_level;

   assign diff_level = diff_decode(diff_clk_in_p, diff_clk_in_n);
   assign next_level = (clk_source_sel == SRC_REF) ? ref_test_clk_in
      : diff_level;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         level <= RST_LEVEL;
         prev_level <= RST_LEVEL;
      end
      else
      begin
         level <= next_level;
         prev_level <= level;
      end
   end

   assign src.level = level;
   assign src.prev_level = prev_level;
   assign src.fall = prev_level & ~level;
   assign src.rise = ~prev_level & level;
endmodule : clk_source_select
`default_nettype wire

// ---- rtl/clock_fanout_buffer.sv ----
// one-to-twelve clock fanout with synchronous enable and three-state
//
// Functional notes
// - select low routes the differential clock
// - select high routes the reference clock
// - enabled outputs toggle; disabled outputs held low
// - enable sampled on selected clock falling edge
// - three-state low floats all output buffers
// - twelve outputs carry the same gated clock
// - enable changes never cause runts or glitches
`timescale 1ns/1ps
`default_nettype none
module clock_fanout_buffer
   import clk_fanout_pkg::*;
#(
   parameter int unsigned N_OUT = OUT_COUNT
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // clock sources
   input wire logic diff_clk_in_p,
   input wire logic diff_clk_in_n,
   input wire logic ref_test_clk_in,
   input wire logic clk_source_sel,
   // output control
   input wire logic sync_out_en,
   input wire logic out_hiz_n,
   // clock outputs, enable low while driving
   output logic [N_OUT-1:0] clk_out,
   output logic [N_OUT-1:0] clk_out_oe_n,
   // captured enable, for status
   output logic gate_en
);
   clk_src_if src ();

   clk_source_select u_select
   (
      .core_clk(core_clk),
      .rst(rst),
      .diff_clk_in_p(diff_clk_in_p),
      .diff_clk_in_n(diff_clk_in_n),
      .ref_test_clk_in(ref_test_clk_in),
      .clk_source_sel(clk_source_sel),
      .src(src.source)
   );

   wire logic next_gate_en;
   wire logic gated_level;
   wire logic drive_en_n;

   // enable only moves while the selected clock is low
   assign next_gate_en = src.fall ? sync_out_en : gate_en;

   always_ff @(posedge core_clk)
   begin
      if (rst)
         gate_en <= RST_GATE_EN;
      else
         gate_en <= next_gate_en;
   end

   // gate is steady across every high phase, so pulses stay whole
   assign gated_level = src.level & gate_en;

   // three-state acts without the clock and ignores the gate
   assign drive_en_n = ~out_hiz_n;

   genvar gi;
   generate
      for (gi = 0; gi < N_OUT; gi++)
      begin : g_out
         always_ff @(posedge core_clk)
         begin
            if (rst)
               clk_out[gi] <= RST_OUT_LEVEL;
            else
               clk_out[gi] <= gated_level;
         end
         assign clk_out_oe_n[gi] = drive_en_n;
      end
   endgenerate

   // helper: selection held for the last three samples
   logic [2:0] sel_hist;
   always_ff @(posedge core_clk)
   begin
      if (rst)
         sel_hist <= 3'h0;
      else
         sel_hist <= {sel_hist[1:0], clk_source_sel};
   end
   wire logic sel_steady;
   assign sel_steady = (sel_hist == {3{clk_source_sel}});

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   property p_sel_diff;
      (clk_source_sel == SRC_DIFF) |=>
         src.level == $past(diff_clk_in_p & ~diff_clk_in_n);
   endproperty
   a_sel_diff: assert property (p_sel_diff)
      else $error("differential clock not routed while select low");

   property p_sel_ref;
      (clk_source_sel == SRC_REF) |=> src.level == $past(ref_test_clk_in);
   endproperty
   a_sel_ref: assert property (p_sel_ref)
      else $error("reference clock not routed while select high");

   property p_gate_pass;
      (src.level && gate_en) |=> (clk_out == {N_OUT{1'b1}});
   endproperty
   a_gate_pass: assert property (p_gate_pass)
      else $error("enabled output did not follow selected clock");

   property p_gate_block;
      (!gate_en) |=> (clk_out == '0);
   endproperty
   a_gate_block: assert property (p_gate_block)
      else $error("disabled output not held low");

   property p_en_capture;
      src.fall |=> (gate_en == $past(sync_out_en));
   endproperty
   a_en_capture: assert property (p_en_capture)
      else $error("enable not captured on falling edge");

   property p_en_hold;
      (!src.fall) |=> $stable(gate_en);
   endproperty
   a_en_hold: assert property (p_en_hold)
      else $error("enable changed away from falling edge");

   property p_hiz;
      (!out_hiz_n) |-> (clk_out_oe_n == {N_OUT{1'b1}});
   endproperty
   a_hiz: assert property (p_hiz)
      else $error("outputs not floated under three-state");

   property p_drive;
      out_hiz_n |-> (clk_out_oe_n == '0);
   endproperty
   a_drive: assert property (p_drive)
      else $error("outputs not driven with three-state high");

   property p_same;
      clk_out == {N_OUT{clk_out[0]}};
   endproperty
   a_same: assert property (p_same)
      else $error("outputs differ from one another");

   // a rise on the output only follows a rise of the source
   property p_no_runt_rise;
      ($rose(clk_out[0]) && sel_steady) |->
         ($past(src.level) && !$past(src.prev_level));
   endproperty
   a_no_runt_rise: assert property (p_no_runt_rise)
      else $error("output rose away from a source rising edge");

   property p_no_runt_fall;
      ($fell(clk_out[0]) && sel_steady) |-> !$past(src.level);
   endproperty
   a_no_runt_fall: assert property (p_no_runt_fall)
      else $error("output fell while the source was high");

   property p_hiz_wins;
      (!out_hiz_n && gate_en) |-> (clk_out_oe_n == {N_OUT{1'b1}});
   endproperty
   a_hiz_wins: assert property (p_hiz_wins)
      else $error("enable overrode three-state");

   c_enable: cover property ($rose(gate_en) ##[1:20] $rose(clk_out[0]));
   c_disable: cover property ($fell(gate_en) ##1 (clk_out == '0));
   c_hiz: cover property (gate_en && !out_hiz_n);
   c_switch: cover property (gate_en && $changed(clk_source_sel));
endmodule : clock_fanout_buffer
`default_nettype wire

// ---- tb/clk_source_model.sv ----
// free-running differential and reference clock sources
`timescale 1ns/1ps
`default_nettype none
module clk_source_model #(
   parameter int DIFF_HALF = 4,
   parameter int REF_HALF = 6
)
(
   // oversampling clock
   input wire logic core_clk,
   // source clocks
   output logic diff_p,
   output logic diff_n,
   output logic ref_clk
);
   int dc = 0;
   int rc = 0;
   initial
   begin
      diff_p = 1'b0;
      ref_clk = 1'b0;
   end
   assign diff_n = ~diff_p;
   // moves on the falling edge, clear of the sampling edge
   always @(negedge core_clk)
   begin
      dc = (dc + 1) % DIFF_HALF;
      rc = (rc + 1) % REF_HALF;
      if (dc == 0)
         diff_p <= ~diff_p;
      if (rc == 0)
         ref_clk <= ~ref_clk;
   end
endmodule : clk_source_model
`default_nettype wire

// ---- tb/tb_clock_fanout_buffer.sv ----
// self-checking bench for the clock fanout buffer
`timescale 1ns/1ps
`default_nettype none
module tb_clock_fanout_buffer;
   import clk_fanout_pkg::*;
   logic core_clk, rst, dp, dn, rc, sel, en, hiz_n, lvl;
   logic gate_en, d1, d2;
   logic [OUT_COUNT-1:0] q, oe_n;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   clk_source_model u_clk_source_model (.core_clk(core_clk),
      .diff_p(dp), .diff_n(dn), .ref_clk(rc));
   clock_fanout_buffer u_clock_fanout_buffer (.core_clk(core_clk),
      .rst(rst), .diff_clk_in_p(dp), .diff_clk_in_n(dn),
      .ref_test_clk_in(rc), .clk_source_sel(sel), .sync_out_en(en),
      .out_hiz_n(hiz_n), .clk_out(q), .clk_out_oe_n(oe_n),
      .gate_en(gate_en));
   // d2 lines up with the output flip-flop: sample, then register
   assign lvl = (sel === SRC_REF) ? rc : (dp & ~dn);
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      d1 <= lvl;
      d2 <= d1;
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         err_count++;
         results();
      end
   end
   task automatic results();
      if (err_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results
   task automatic check(string what, logic [OUT_COUNT-1:0] exp,
      logic [OUT_COUNT-1:0] got);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic tick(int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   task automatic drive(logic s, logic e, logic h);
      @(negedge core_clk);
      sel = s;
      en = e;
      hiz_n = h;
   endtask : drive
   task automatic window(string what, logic on);
      repeat (24)
      begin
         tick(1);
         check(what, on ? {OUT_COUNT{d2}} : '0, q);
      end
   endtask : window
   task automatic t_route(logic s);
      drive(s, 1'b1, 1'b1);
      tick(30);
      check("oe_n", '0, oe_n);
      window("clk_out", 1'b1);
   endtask : t_route
   task automatic t_capture();
      int n = 0;
      drive(SRC_REF, 1'b1, 1'b1);
      tick(30);
      while (!(d1 === 1'b1 && d2 === 1'b0) && n < 20)
      begin
         tick(1);
         n++;
      end
      drive(SRC_REF, 1'b0, 1'b1);
      tick(2);
      check("gate_en held", OUT_COUNT'(1), OUT_COUNT'(gate_en));
      tick(14);
      check("gate_en off", '0, OUT_COUNT'(gate_en));
      window("clk_out off", 1'b0);
      drive(SRC_REF, 1'b1, 1'b1);
      tick(14);
      check("gate_en on", OUT_COUNT'(1), OUT_COUNT'(gate_en));
   endtask : t_capture
   task automatic t_hiz();
      drive(SRC_DIFF, 1'b1, 1'b0);
      #1;
      check("oe_n float", '1, oe_n);
      tick(20);
      check("gate_en float", OUT_COUNT'(1), OUT_COUNT'(gate_en));
      check("oe_n float", '1, oe_n);
      drive(SRC_DIFF, 1'b1, 1'b1);
      #1;
      check("oe_n drive", '0, oe_n);
   endtask : t_hiz
   initial
   begin
      rst = 1'b1;
      sel = SRC_DIFF;
      en = 1'b0;
      hiz_n = 1'b1;
      repeat (20) @(negedge core_clk);
      rst = 1'b0;
      tick(1);
      check("gate_en rst", OUT_COUNT'(RST_GATE_EN), OUT_COUNT'(gate_en));
      t_route(SRC_DIFF);
      t_route(SRC_REF);
      t_capture();
      t_hiz();
      results();
   end
endmodule : tb_clock_fanout_buffer
`default_nettype wire
